/* src/dfm_pkg.sv */
`default_nettype none
package dfm_pkg;

    // ****************************************************************
    // Register map (APB byte addresses, one word each)
    // ****************************************************************
    localparam logic [7:0] ADDR_DI_CFG    = 8'h00; // Input function selects
    localparam logic [7:0] ADDR_AIN_CFG   = 8'h04; // Analog trip setup
    localparam logic [7:0] ADDR_STATUS    = 8'h08; // Live state, read only
    localparam logic [7:0] ADDR_FAULT_CLR = 8'h0C; // Write one to clear

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned DI_SEL_W     = 5;  // Width of one select
    localparam int unsigned DI_SEL_STEP  = 8;  // Byte lane per input
    localparam int unsigned AIN_TYPE_LSB = 0;  // Trip type field
    localparam int unsigned AIN_LVL_LSB  = 8;  // Trip level, percent
    localparam int unsigned AIN_DLY_LSB  = 16; // Trip delay, tenths s
    localparam int unsigned ST_DIN_LSB   = 0;  // Synced input levels
    localparam int unsigned ST_DI_FLT    = 8;  // Latched input fault
    localparam int unsigned ST_AIN_FLT   = 9;  // Latched analog fault
    localparam int unsigned ST_AIN_COND  = 10; // Raw trip condition

    // ****************************************************************
    // Function and trip type codes
    // ****************************************************************
    typedef enum logic [4:0] {
        FN_OFF, FN_STOP, FN_FAULT_ON_HIGH, FN_FAULT_ON_LOW, FN_FAULT_RESET,
        FN_DISCONNECT_MONITOR, FN_INLINE_CONFIRM, FN_BYPASS_CONFIRM,
        FN_EMERGENCY_OVERLOAD_CLEAR, FN_SOURCE_SELECT, FN_HEATER_OFF,
        FN_HEATER_ON, FN_RAMP_SELECT, FN_SLOW_FWD, FN_SLOW_REV,
        FN_BRAKE_INHIBIT, FN_BRAKE_PERMIT
    } dfm_fn_t;

    typedef enum logic [1:0] {
        AT_OFF, AT_LOW, AT_HIGH
    } dfm_trip_t;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam dfm_fn_t    RST_SEL_ONE   = FN_STOP;
    localparam dfm_fn_t    RST_SEL_REST  = FN_OFF;
    localparam dfm_trip_t  RST_TRIP_TYPE = AT_OFF;
    localparam logic [7:0] RST_TRIP_LVL  = 8'h32; // 50 percent
    localparam logic [9:0] RST_TRIP_DLY  = 10'h001; // 0.1 s

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;  // 100 MHz
    localparam int unsigned TICK_MS       = 100; // Delay unit, 0.1 s
    localparam int unsigned TICK_CYCLES   =
        (TICK_MS * 1000000) / CLK_PERIOD_NS;

    // ****************************************************************
    // Function outputs carried together
    // ****************************************************************
    typedef struct packed {
        logic stop_cmd;                 // Three-wire stop requested
        logic fault_reset;              // Pulse, clear latched faults
        logic disconnect_monitor;       // Disconnect switch closed
        logic inline_fb;                // Inline contactor feedback
        logic bypass_fb;                // Bypass / second_contactor
        logic emergency_overload_clear; // Pulse, clear overload
        logic remote_sel;               // Remote control source
        logic heater_off;               // Force motor heating off
        logic heater_on;                // Force motor heating on
        logic ramp2_sel;                // Second acceleration ramp
        logic slow_fwd;                 // Slow speed forward
        logic slow_rev;                 // Slow speed reverse
        logic brake_inhibit;            // Inhibit DC injection brake
        logic brake_permit;             // Permit DC injection brake
    } dfm_func_t;

endpackage
`default_nettype wire

/* src/dfm_mapper.sv */
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module dfm_mapper #(
    parameter int unsigned N_IN        = 3,
    parameter int unsigned TICK_CYCLES = dfm_pkg::TICK_CYCLES
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    output var  logic [31:0]      PRDATA,
    output var  logic             PREADY,
    output var  logic             PSLVERR,
    input  wire logic [N_IN-1:0]  DIN,
    input  wire logic [7:0]       AIN_LEVEL,
    input  wire logic             MOTOR_RUNNING,
    input  wire logic             OVERLOAD_TRIPPED,
    output var  dfm_pkg::dfm_func_t FUNC,
    output var  logic             DI_FAULT,
    output var  logic             AIN_FAULT
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [N_IN-1:0]   din_meta_ff;    // First sync stage only
    logic [N_IN-1:0]   din_ff;         // Synchronised levels
    logic [N_IN-1:0]   din_prev_ff;    // For rising-edge detect
    dfm_pkg::dfm_fn_t  sel_ff [N_IN];  // Per-input function select
    dfm_pkg::dfm_trip_t trip_type_ff;  // Analog trip type
    logic [7:0]        trip_lvl_ff;    // Trip level, percent
    logic [9:0]        trip_dly_ff;    // Trip delay, ticks
    logic [31:0]       tick_cnt_ff;    // Prescaler to 0.1 s
    logic              tick;           // One clock every 0.1 s
    logic [9:0]        trip_cnt_ff;    // Ticks condition held
    logic              ain_cond;       // Raw comparator result
    logic              wr_en;          // Write committed this edge
    logic              rd_setup;       // First access cycle
    logic              addr_ok;        // Decoded address
    dfm_pkg::dfm_func_t nxt_func;      // Decoded function levels
    logic              di_fault_set;   // Input fault this cycle
    logic              clr_faults;     // Reset by input edge
    logic [31:0]       nxt_prdata;     // Read mux
    logic [N_IN-1:0]   din_rise;       // Rising edges

    // ****************************************************************
    // APB slave, one wait state
    // ****************************************************************
    assign rd_setup = PSEL && PENABLE && !PREADY;
    assign wr_en    = PSEL && PENABLE && PREADY && PWRITE;
    assign addr_ok  = (PADDR == dfm_pkg::ADDR_DI_CFG)  ||
                      (PADDR == dfm_pkg::ADDR_AIN_CFG) ||
                      (PADDR == dfm_pkg::ADDR_STATUS)  ||
                      (PADDR == dfm_pkg::ADDR_FAULT_CLR);

    // Ready rises on the second access cycle, then drops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= rd_setup;
            PSLVERR <= rd_setup && !addr_ok;
        end
    end

    // Read mux; unmapped and clear register read as zero
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (PADDR)
            dfm_pkg::ADDR_DI_CFG: begin
                for (int i = 0; i < N_IN; i++) begin
                    nxt_prdata[i*dfm_pkg::DI_SEL_STEP +: dfm_pkg::DI_SEL_W]
                        = sel_ff[i];
                end
            end
            dfm_pkg::ADDR_AIN_CFG: begin
                nxt_prdata[dfm_pkg::AIN_TYPE_LSB +: 2] = trip_type_ff;
                nxt_prdata[dfm_pkg::AIN_LVL_LSB +: 8]  = trip_lvl_ff;
                nxt_prdata[dfm_pkg::AIN_DLY_LSB +: 10] = trip_dly_ff;
            end
            dfm_pkg::ADDR_STATUS: begin
                nxt_prdata[dfm_pkg::ST_DIN_LSB +: N_IN] = din_ff;
                nxt_prdata[dfm_pkg::ST_DI_FLT]   = DI_FAULT;
                nxt_prdata[dfm_pkg::ST_AIN_FLT]  = AIN_FAULT;
                nxt_prdata[dfm_pkg::ST_AIN_COND] = ain_cond;
            end
            default: begin
                nxt_prdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured in the wait cycle, stable at ready
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : nxt_prdata;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Function selects; codes above the last one act as off
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < N_IN; i++) begin
                // First input stops, the others do nothing
                sel_ff[i] <= (i == 0) ? dfm_pkg::RST_SEL_ONE
                                      : dfm_pkg::RST_SEL_REST;
            end
        end else if (wr_en && PADDR == dfm_pkg::ADDR_DI_CFG) begin
            for (int i = 0; i < N_IN; i++) begin
                // Each input keeps its own select
                sel_ff[i] <= dfm_pkg::dfm_fn_t'(PWDATA[i*dfm_pkg::DI_SEL_STEP
                              +: dfm_pkg::DI_SEL_W]);
            end
        end
    end

    // Analog trip setup; off after reset
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trip_type_ff <= dfm_pkg::RST_TRIP_TYPE;
            trip_lvl_ff  <= dfm_pkg::RST_TRIP_LVL;
            trip_dly_ff  <= dfm_pkg::RST_TRIP_DLY;
        end else if (wr_en && PADDR == dfm_pkg::ADDR_AIN_CFG) begin
            trip_type_ff <= dfm_pkg::dfm_trip_t'(
                            PWDATA[dfm_pkg::AIN_TYPE_LSB +: 2]);
            trip_lvl_ff  <= PWDATA[dfm_pkg::AIN_LVL_LSB +: 8];
            trip_dly_ff  <= PWDATA[dfm_pkg::AIN_DLY_LSB +: 10];
        end
    end

    // ****************************************************************
    // Input synchroniser
    // ****************************************************************
    // Field wiring is asynchronous; two stages before any decode
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            din_meta_ff <= '0;
            din_ff      <= '0;
            din_prev_ff <= '0;
        end else begin
            din_meta_ff <= DIN;
            din_ff      <= din_meta_ff;
            din_prev_ff <= din_ff;
        end
    end
    assign din_rise = din_ff & ~din_prev_ff;

    // ****************************************************************
    // Function decode
    // ****************************************************************
    // Two inputs on one function are ORed together
    always_comb begin
        nxt_func     = '0;
        di_fault_set = 1'b0;
        for (int i = 0; i < N_IN; i++) begin
            case (sel_ff[i])
                dfm_pkg::FN_OFF: begin
                    di_fault_set = di_fault_set;
                end
                dfm_pkg::FN_STOP: begin
                    // Normally closed stop: open wire means stop
                    nxt_func.stop_cmd |= !din_ff[i];
                end
                dfm_pkg::FN_FAULT_ON_HIGH: begin
                    di_fault_set |= din_ff[i];
                end
                dfm_pkg::FN_FAULT_ON_LOW: begin
                    di_fault_set |= !din_ff[i];
                end
                dfm_pkg::FN_FAULT_RESET: begin
                    nxt_func.fault_reset |= din_rise[i];
                end
                dfm_pkg::FN_DISCONNECT_MONITOR: begin
                    nxt_func.disconnect_monitor |= din_ff[i];
                end
                dfm_pkg::FN_INLINE_CONFIRM: begin
                    nxt_func.inline_fb |= din_ff[i];
                end
                dfm_pkg::FN_BYPASS_CONFIRM: begin
                    nxt_func.bypass_fb |= din_ff[i];
                end
                dfm_pkg::FN_EMERGENCY_OVERLOAD_CLEAR: begin
                    // Only meaningful once an overload trip exists
                    nxt_func.emergency_overload_clear |=
                        din_rise[i] && OVERLOAD_TRIPPED;
                end
                dfm_pkg::FN_SOURCE_SELECT: begin
                    nxt_func.remote_sel |= din_ff[i];
                end
                dfm_pkg::FN_HEATER_OFF: begin
                    nxt_func.heater_off |= din_ff[i];
                end
                dfm_pkg::FN_HEATER_ON: begin
                    nxt_func.heater_on |= din_ff[i];
                end
                dfm_pkg::FN_RAMP_SELECT: begin
                    nxt_func.ramp2_sel |= din_ff[i];
                end
                dfm_pkg::FN_SLOW_FWD: begin
                    nxt_func.slow_fwd |= din_ff[i];
                end
                dfm_pkg::FN_SLOW_REV: begin
                    nxt_func.slow_rev |= din_ff[i];
                end
                dfm_pkg::FN_BRAKE_INHIBIT: begin
                    nxt_func.brake_inhibit |= din_ff[i];
                end
                dfm_pkg::FN_BRAKE_PERMIT: begin
                    nxt_func.brake_permit |= din_ff[i];
                end
                default: begin
                    di_fault_set = di_fault_set; // Unused codes: off
                end
            endcase
        end
    end

    // Function outputs registered straight to the pins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            FUNC <= '0;
        end else begin
            FUNC <= nxt_func;
        end
    end

    // ****************************************************************
    // Analog trip comparator
    // ****************************************************************
    always_comb begin
        case (trip_type_ff)
            dfm_pkg::AT_LOW:  ain_cond = AIN_LEVEL < trip_lvl_ff;
            dfm_pkg::AT_HIGH: ain_cond = AIN_LEVEL > trip_lvl_ff;
            default:          ain_cond = 1'b0;
        endcase
    end

    // 0.1 s prescaler for the delay count
    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_cnt_ff <= 32'h0000_0000;
        end else begin
            tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h1;
        end
    end

    // Persistence count; restarts whenever condition or run drops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trip_cnt_ff <= 10'h000;
        end else if (!(ain_cond && MOTOR_RUNNING)) begin
            trip_cnt_ff <= 10'h000;
        end else if (tick && trip_cnt_ff != 10'h3FF) begin
            trip_cnt_ff <= trip_cnt_ff + 10'h001;
        end
    end

    // ****************************************************************
    // Latched faults; a new fault beats any clear
    // ****************************************************************
    assign clr_faults = nxt_func.fault_reset;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DI_FAULT <= 1'b0;
        end else if (di_fault_set) begin
            DI_FAULT <= 1'b1;
        end else if (clr_faults || (wr_en &&
                 PADDR == dfm_pkg::ADDR_FAULT_CLR &&
                 PWDATA[dfm_pkg::ST_DI_FLT])) begin
            DI_FAULT <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            AIN_FAULT <= 1'b0;
        end else if (ain_cond && MOTOR_RUNNING &&
                     trip_cnt_ff >= trip_dly_ff) begin
            AIN_FAULT <= 1'b1;
        end else if (clr_faults || (wr_en &&
                 PADDR == dfm_pkg::ADDR_FAULT_CLR &&
                 PWDATA[dfm_pkg::ST_AIN_FLT])) begin
            AIN_FAULT <= 1'b0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_stop_level: assert property (
        (sel_ff[0] == dfm_pkg::FN_STOP && !din_ff[0]) |=> FUNC.stop_cmd)
        else $error("stop command missing");
    a_high_fault: assert property (
        (sel_ff[0] == dfm_pkg::FN_FAULT_ON_HIGH && din_ff[0]) |=> DI_FAULT)
        else $error("fault on high not latched");
    a_low_fault: assert property (
        (sel_ff[1] == dfm_pkg::FN_FAULT_ON_LOW && !din_ff[1]) |=> DI_FAULT)
        else $error("fault on low not latched");
    a_off_quiet: assert property (
        (sel_ff[0] == dfm_pkg::FN_OFF && sel_ff[1] == dfm_pkg::FN_OFF &&
         sel_ff[2] == dfm_pkg::FN_OFF) |=> (FUNC == '0))
        else $error("off input produced a function");
    a_reset_pulse: assert property (
        FUNC.fault_reset |=> !FUNC.fault_reset)
        else $error("fault reset not a pulse");
    a_remote_sel: assert property (
        (sel_ff[2] == dfm_pkg::FN_SOURCE_SELECT && sel_ff[0] !=
         dfm_pkg::FN_SOURCE_SELECT && sel_ff[1] != dfm_pkg::FN_SOURCE_SELECT)
        |=> (FUNC.remote_sel == $past(din_ff[2])))
        else $error("source select mismatch");
    a_ol_clear_gate: assert property (
        FUNC.emergency_overload_clear |-> $past(OVERLOAD_TRIPPED))
        else $error("overload clear without trip");
    a_ain_off: assert property (
        (trip_type_ff == dfm_pkg::AT_OFF && !$past(AIN_FAULT)) |-> !AIN_FAULT)
        else $error("analog fault while off");
    a_ain_running: assert property (
        $rose(AIN_FAULT) |-> $past(MOTOR_RUNNING) && $past(ain_cond))
        else $error("analog fault while stopped");
    a_sync_delay: assert property (
        $rose(din_ff[0]) |-> $past(DIN[0], 2))
        else $error("input not synchronised");
    a_apb_wait: assert property (
        (PSEL && PENABLE && !PREADY) |=> PREADY)
        else $error("apb ready late");

    c_fault_high: cover property (
        sel_ff[0] == dfm_pkg::FN_FAULT_ON_HIGH ##1 $rose(DI_FAULT));
    c_fault_reset: cover property (DI_FAULT ##1 FUNC.fault_reset ##1
        !DI_FAULT);
    c_ain_trip: cover property ($rose(AIN_FAULT));
    c_slverr: cover property (PREADY && PSLVERR);

endmodule
`default_nettype wire

/* bench/dfm_field.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Field wiring model: registers what the bench asks for
// ****************************************************************
module dfm_field (
    input  wire logic       CLK,
    input  wire logic [2:0] WANT_DIN,
    input  wire logic [7:0] WANT_LVL,
    input  wire logic       WANT_RUN,
    input  wire logic       WANT_OVL,
    output var  logic [2:0] DIN,
    output var  logic [7:0] AIN_LEVEL,
    output var  logic       MOTOR_RUNNING,
    output var  logic       OVERLOAD_TRIPPED
);
    // Contacts change only after an edge, like real wiring
    always_ff @(posedge CLK) begin
        DIN              <= WANT_DIN;
        AIN_LEVEL        <= WANT_LVL;
        MOTOR_RUNNING    <= WANT_RUN;
        OVERLOAD_TRIPPED <= WANT_OVL;
    end
endmodule
`default_nettype wire

/* bench/test_digital_input_function_mapper.sv */
`timescale 1ns/10ps
`default_nettype none
module test_digital_input_function_mapper;
    logic               clk = 1'b0;  // 100 MHz
    logic               rst = 1'b1;  // Async reset
    logic               psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]         padr = 8'h00;
    logic [31:0]        pwd = 32'h0, prd, rd;
    logic               prdy, perr, dif, aif;
    logic [2:0]         wdin = 3'h0, din;
    logic [7:0]         wlvl = 8'h00, lvl;
    logic               wrun = 1'b0, wovl = 1'b0, run, ovl;
    dfm_pkg::dfm_func_t func;        // Function outputs
    int                 mismatches = 0, total_checks = 0, n;
    always #5 clk = ~clk;
    dfm_field fld (.CLK(clk), .WANT_DIN(wdin), .WANT_LVL(wlvl),
        .WANT_RUN(wrun), .WANT_OVL(wovl), .DIN(din), .AIN_LEVEL(lvl),
        .MOTOR_RUNNING(run), .OVERLOAD_TRIPPED(ovl));
    // Short tick so analog delays stay within a short run
    dfm_mapper #(.N_IN(3), .TICK_CYCLES(10)) uut (.CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .DIN(din), .AIN_LEVEL(lvl), .MOTOR_RUNNING(run),
        .OVERLOAD_TRIPPED(ovl), .FUNC(func), .DI_FAULT(dif),
        .AIN_FAULT(aif));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // APB transfer; waits for the slave, releases after the ready edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulses(input int b);
        n = 0;
        repeat (10) @(posedge clk) if (func[b] === 1'b1) n++;
    endtask
    function automatic logic [13:0] exp_fn(input logic [4:0] c,
                                           input logic hi);
        exp_fn = 14'h0000;
        if (c == 5'h01 && !hi) exp_fn = 14'h2000;
        if (hi && c > 5'h04 && c < 5'h11 && c != 5'h08)
            exp_fn = 14'h0001 << (5'h10 - c);
    endfunction
    task automatic t_reset();
        repeat (4) @(posedge clk);
        chk(func, 32'h2000);
        apb(1'b0, dfm_pkg::ADDR_DI_CFG, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, dfm_pkg::ADDR_AIN_CFG, 32'h0);
        chk(rd, 32'h00013200);
        apb(1'b0, 8'h10, 32'h0);
        chk({perr, rd}, 33'h0);
    endtask
    // Codes 0 to 17 on the middle input, low then high
    task automatic t_codes();
        for (int c = 0; c < 18; c++) begin
            apb(1'b1, dfm_pkg::ADDR_DI_CFG, 32'(c) << 8);
            repeat (6) @(posedge clk);
            chk(func, exp_fn(5'(c), 1'b0));
            chk(dif, c == 3);
            wdin <= 3'h2;
            repeat (6) @(posedge clk);
            chk(func, exp_fn(5'(c), 1'b1));
            chk(dif, c == 2 || c == 3);
            wdin <= 3'h0;
            apb(1'b1, dfm_pkg::ADDR_DI_CFG, 32'h0);
            apb(1'b1, dfm_pkg::ADDR_FAULT_CLR, 32'h300);
        end
    endtask
    // Fault high on input 1, reset on 2, overload clear on 3
    task automatic t_pulses();
        apb(1'b1, dfm_pkg::ADDR_DI_CFG, 32'h00080402);
        wdin <= 3'h1;
        @(posedge clk) wdin <= 3'h0;
        repeat (8) @(posedge clk);
        chk(dif, 1'b1);
        wdin <= 3'h2;
        pulses(12);
        chk(n, 1);
        chk(dif, 1'b0);
        wovl <= 1'b1;
        wdin <= 3'h6;
        pulses(8);
        chk(n, 1);
    endtask
    task automatic t_analog(input logic [31:0] cfg, input logic [7:0] l,
                            input logic r, input logic f);
        apb(1'b1, dfm_pkg::ADDR_AIN_CFG, cfg);
        wlvl <= l;
        wrun <= r;
        apb(1'b1, dfm_pkg::ADDR_FAULT_CLR, 32'h200);
        repeat (8) @(posedge clk);
        chk(aif, 1'b0);
        repeat (40) @(posedge clk);
        chk(aif, f);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_pulses();
        t_analog(32'h00023201, 8'h20, 1'b0, 1'b0);
        t_analog(32'h00023201, 8'h20, 1'b1, 1'b1);
        t_analog(32'h00023202, 8'h20, 1'b1, 1'b0);
        t_analog(32'h00023202, 8'h33, 1'b1, 1'b1);
        t_analog(32'h00023200, 8'h20, 1'b1, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
